// >>> hw/pet_pkg.sv
package pet_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] PET_IDX_PAGE_SELECT = 8'h13;
  localparam logic [7:0] PET_IDX_TRIGGER_CONFIGURATION = 8'h14;
  localparam logic [7:0] PET_IDX_EVENT_UNIT_CONFIGURATION = 8'h15;
  localparam logic [7:0] PET_IDX_EVENT_QUEUE_STATUS = 8'h1e;
  localparam logic [7:0] PET_IDX_EVENT_TIMESTAMP_DATA = 8'h1f;
  localparam logic [2:0] PET_PAGE_STATUS = 3'h4;
  localparam logic [2:0] PET_PAGE_CONFIG = 3'h5;
  localparam logic [2:0] PET_PAGE_RST = 3'h0;
  localparam int PET_UNITS = 8;
  // indexed configuration registers
  localparam int PET_STROBE_BIT = 0;
  localparam int PET_SEL_LO = 1;
  localparam int PET_SEL_HI = 3;
  localparam int PET_TRIG_CFG_HI = 15;
  localparam int PET_TRIG_CFG_LO = 7;
  localparam int PET_PULSE_OUTPUT_SELECT_BIT = 15;
  localparam int PET_TRIG_PERIODIC_BIT = 14;
  localparam int PET_TRIG_LATE_BIT = 13;
  localparam int PET_COMPLETION_REPORT_ENABLE_BIT = 12;
  localparam int PET_ROUTE_LO = 8;
  localparam int PET_INVERT_OUTPUT_MODE_BIT = 7;
  localparam int PET_EVT_CFG_HI = 14;
  localparam int PET_EVT_CFG_LO = 8;
  localparam int PET_EVT_RISE_BIT = 14;
  localparam int PET_EVT_FALL_BIT = 13;
  localparam int PET_EVT_SINGLE_BIT = 12;
  localparam logic [3:0] PET_PIN_MAX = 4'hc;
  // event queue status fields
  localparam int PET_ST_DET_BIT = 0;
  localparam int PET_ST_MULT_BIT = 1;
  localparam int PET_ST_NUM_LO = 2;
  localparam int PET_ST_RF_BIT = 5;
  localparam int PET_ST_LEN_LO = 6;
  localparam int PET_ST_MISSED_LO = 8;
  localparam logic [2:0] PET_MISSED_MAX = 3'h7;
  localparam int PET_QUEUE_DEPTH = 8;

  typedef enum logic [2:0] {
    PET_SEQ_EXT = 3'b000,
    PET_SEQ_NS_LO = 3'b001,
    PET_SEQ_NS_HI = 3'b011,
    PET_SEQ_SEC_LO = 3'b010,
    PET_SEQ_SEC_HI = 3'b110,
    PET_SEQ_DONE = 3'b111
  } pet_seq_e;

  typedef struct packed {
    logic [7:0] det;
    logic [7:0] rise;
    logic [29:0] ns;
    logic [31:0] sec;
    logic [1:0] len;
    logic [2:0] missed;
  } pet_entry_s;
endpackage

// >>> hw/pet_cfg_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pet_cfg_if;
  logic wr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  modport host(output wr, output wdata, input rdata);
  modport store(input wr, input wdata, output rdata);
endinterface
`default_nettype wire

// >>> hw/pet_event_queue.sv
`timescale 1ns/1ps
`default_nettype none
module pet_event_queue import pet_pkg::*; #(
  parameter int DEPTH = PET_QUEUE_DEPTH
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // capture side
  input wire logic i_push,
  input wire logic [7:0] i_det,
  input wire logic [7:0] i_rise,
  input wire logic [29:0] i_ns,
  input wire logic [31:0] i_sec,
  // drain side
  input wire logic i_pop,
  output logic o_empty,
  output pet_entry_s o_head
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

  typedef struct packed {
    pet_entry_s [DEPTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
    logic [29:0] last_ns;
    logic [31:0] last_sec;
    logic [2:0] missed;
  } pet_q_s;

  pet_q_s q;
  pet_q_s next_q;

  always_comb begin
    logic do_pop;
    logic do_push;
    pet_entry_s e;
    do_pop = i_pop && (q.cnt != '0);
    do_push = i_push && (i_det != '0) && ((q.cnt != FULL) || do_pop);
    e = '0;
    next_q = q;
    if (do_push) begin
      e.det = i_det;
      e.rise = i_rise;
      e.ns = i_ns;
      e.sec = i_sec;
      e.missed = q.missed;
      // count of changed low-order words, minus one
      if (i_sec[31:16] != q.last_sec[31:16]) e.len = 2'd3;
      else if (i_sec[15:0] != q.last_sec[15:0]) e.len = 2'd2;
      else if (i_ns[29:16] != q.last_ns[29:16]) e.len = 2'd1;
      else e.len = 2'd0;
      next_q.mem[q.wr] = e;
      next_q.wr = (q.wr == LAST) ? '0 : q.wr + 1'b1;
      next_q.last_ns = i_ns;
      next_q.last_sec = i_sec;
      next_q.missed = '0;
    end else if (i_push && (i_det != '0) && (q.missed != PET_MISSED_MAX)) begin
      next_q.missed = q.missed + 1'b1;
    end
    if (do_pop) next_q.rd = (q.rd == LAST) ? '0 : q.rd + 1'b1;
    next_q.cnt = q.cnt + (AW + 1)'(do_push) - (AW + 1)'(do_pop);
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) q <= '0;
    else q <= next_q;
  end

  assign o_empty = (q.cnt == '0);
  assign o_head = q.mem[q.rd];
endmodule
`default_nettype wire

// >>> hw/pet_cfg_store.sv
`timescale 1ns/1ps
`default_nettype none
module pet_cfg_store import pet_pkg::*; #(
  parameter int N = PET_UNITS,
  parameter int HI = PET_TRIG_CFG_HI,
  parameter int LO = PET_TRIG_CFG_LO
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // register access
  pet_cfg_if.store bus,
  // stored settings, unit 0 lowest
  output logic [N*(HI-LO+1)-1:0] o_cfg
);
  localparam int W = HI - LO + 1;

  typedef struct packed {
    logic [N-1:0][W-1:0] cfg;
    logic [2:0] sel;
  } pet_store_s;

  pet_store_s q;
  pet_store_s next_q;

  always_comb begin
    logic [2:0] s;
    s = bus.wdata[PET_SEL_HI:PET_SEL_LO];
    next_q = q;
    if (bus.wr) begin
      next_q.sel = s;
      if (bus.wdata[PET_STROBE_BIT] && (32'(s) < N)) next_q.cfg[s] = bus.wdata[HI:LO];
    end
  end

  always_comb begin
    bus.rdata = '0;
    if (32'(q.sel) < N) bus.rdata[HI:LO] = q.cfg[q.sel];
    bus.rdata[PET_SEL_HI:PET_SEL_LO] = q.sel;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) q <= '0;
    else q <= next_q;
  end

  assign o_cfg = q.cfg;
endmodule
`default_nettype wire

// >>> hw/pet_top.sv
// Register access over AHB-Lite was decided locally.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - with simultaneous events, first data read returns extended status word
// - timestamp read as ns low, ns high, seconds low, seconds high
// - upper nanoseconds word has its top two bits zero
// - each status read advances queue to next timestamp
// - data register valid only while status shows an event
// - even bit 2n flags unit n edge; flags clear on read
// - odd bit 2n+1 gives unit n direction, 1 rising
// - write with strobe clear latches select; read returns that trigger
// - control bit 15 makes trigger emit a pulse
// - control bit 14 makes trigger periodic, else single shot
// - bit 13 fires late triggers at once; periodic late gives no notice
// - bit 12 enables completion and late-error reporting
// - field 11:8 routes trigger to pin 1..12; zero unconnected
// - bit 7 selects toggle mode, inverting output at trigger time
// - bits 6:4 ignore writes and read zero
// - field 3:1 selects the unit addressed
// - bit 0 strobes a configuration write and reads zero
// - event unit configuration uses the same indexed scheme
// - status zero means no timestamp is waiting
// - length field gives new low-order words minus one
// - status bit 1 flags multiple events and extended word first
module pet_top import pet_pkg::*; #(
  parameter int QUEUE_DEPTH = PET_QUEUE_DEPTH
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_resetn,
  // ahb-lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  // captured events from the event units
  input wire logic i_cap_valid,
  input wire logic [7:0] i_cap_det,
  input wire logic [7:0] i_cap_rise,
  input wire logic [29:0] i_cap_ns,
  input wire logic [31:0] i_cap_sec,
  // trigger unit controls, one bit or nibble per unit
  output logic [PET_UNITS-1:0] o_pulse_output_select,
  output logic [PET_UNITS-1:0] o_trig_periodic,
  output logic [PET_UNITS-1:0] o_trig_fire_late,
  output logic [PET_UNITS-1:0] o_trig_report_done,
  output logic [PET_UNITS-1:0] o_trig_report_late,
  output logic [PET_UNITS-1:0] o_invert_output_mode,
  output logic [PET_UNITS*4-1:0] o_trig_pin_route,
  // event unit controls
  output logic [PET_UNITS-1:0] o_evt_rise_en,
  output logic [PET_UNITS-1:0] o_evt_fall_en,
  output logic [PET_UNITS-1:0] o_evt_single,
  output logic [PET_UNITS*4-1:0] o_evt_pin_route
);
  localparam int TW = PET_TRIG_CFG_HI - PET_TRIG_CFG_LO + 1;
  localparam int EW = PET_EVT_CFG_HI - PET_EVT_CFG_LO + 1;

  typedef struct packed {
    logic [2:0] page;
    logic pend;
    logic pend_write;
    logic pend_mapped;
    logic [7:0] pend_idx;
    logic hready;
    logic [15:0] hrdata;
    pet_entry_s cur;
    logic cur_valid;
    pet_seq_e seq;
    logic [PET_UNITS-1:0] pulse_output_select;
    logic [PET_UNITS-1:0] trig_periodic;
    logic [PET_UNITS-1:0] trig_fire_late;
    logic [PET_UNITS-1:0] trig_report_done;
    logic [PET_UNITS-1:0] trig_report_late;
    logic [PET_UNITS-1:0] invert_output_mode;
    logic [PET_UNITS*4-1:0] trig_route;
    logic [PET_UNITS-1:0] evt_rise;
    logic [PET_UNITS-1:0] evt_fall;
    logic [PET_UNITS-1:0] evt_single;
    logic [PET_UNITS*4-1:0] evt_route;
  } pet_top_s;

  pet_top_s q;
  pet_top_s next_q;
  logic [1:0] rst_sync;
  logic rst_n;
  logic q_pop;
  logic q_empty;
  pet_entry_s q_head;
  logic [TW*PET_UNITS-1:0] trig_cfg;
  logic [EW*PET_UNITS-1:0] evt_cfg;
  logic [15:0] ext_word;
  logic [PET_UNITS-1:0] dec_pulse;
  logic [PET_UNITS-1:0] dec_periodic;
  logic [PET_UNITS-1:0] dec_late;
  logic [PET_UNITS-1:0] dec_done;
  logic [PET_UNITS-1:0] dec_late_rpt;
  logic [PET_UNITS-1:0] dec_toggle;
  logic [PET_UNITS*4-1:0] dec_troute;
  logic [PET_UNITS-1:0] dec_erise;
  logic [PET_UNITS-1:0] dec_efall;
  logic [PET_UNITS-1:0] dec_esingle;
  logic [PET_UNITS*4-1:0] dec_eroute;

  pet_cfg_if trig_bus ();
  pet_cfg_if evt_bus ();

  // reset release
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) rst_sync <= 2'b00;
    else rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  pet_event_queue #(
    .DEPTH(QUEUE_DEPTH)
  ) u_queue (
    .i_clk(i_core_clk),
    .i_rst_n(rst_n),
    .i_push(i_cap_valid),
    .i_det(i_cap_det),
    .i_rise(i_cap_rise),
    .i_ns(i_cap_ns),
    .i_sec(i_cap_sec),
    .i_pop(q_pop),
    .o_empty(q_empty),
    .o_head(q_head)
  );

  pet_cfg_store #(
    .N(PET_UNITS),
    .HI(PET_TRIG_CFG_HI),
    .LO(PET_TRIG_CFG_LO)
  ) u_trig_store (
    .i_clk(i_core_clk),
    .i_rst_n(rst_n),
    .bus(trig_bus.store),
    .o_cfg(trig_cfg)
  );

  pet_cfg_store #(
    .N(PET_UNITS),
    .HI(PET_EVT_CFG_HI),
    .LO(PET_EVT_CFG_LO)
  ) u_evt_store (
    .i_clk(i_core_clk),
    .i_rst_n(rst_n),
    .bus(evt_bus.store),
    .o_cfg(evt_cfg)
  );

  // per-unit decode of stored settings and extended status layout
  for (genvar i = 0; i < PET_UNITS; i++) begin : g_unit
    logic [TW-1:0] tc;
    logic [EW-1:0] ec;
    logic [3:0] tr;
    logic [3:0] er;
    assign tc = trig_cfg[i*TW +: TW];
    assign ec = evt_cfg[i*EW +: EW];
    assign tr = tc[PET_ROUTE_LO-PET_TRIG_CFG_LO +: 4];
    assign er = ec[PET_ROUTE_LO-PET_EVT_CFG_LO +: 4];
    assign dec_pulse[i] = tc[PET_PULSE_OUTPUT_SELECT_BIT-PET_TRIG_CFG_LO];
    assign dec_periodic[i] = tc[PET_TRIG_PERIODIC_BIT-PET_TRIG_CFG_LO];
    assign dec_late[i] = tc[PET_TRIG_LATE_BIT-PET_TRIG_CFG_LO];
    assign dec_done[i] = tc[PET_COMPLETION_REPORT_ENABLE_BIT-PET_TRIG_CFG_LO];
    // periodic outputs that start late stay silent
    assign dec_late_rpt[i] = dec_done[i] && !(dec_periodic[i] && dec_late[i]);
    assign dec_toggle[i] = tc[PET_INVERT_OUTPUT_MODE_BIT-PET_TRIG_CFG_LO];
    assign dec_troute[i*4 +: 4] = (tr <= PET_PIN_MAX) ? tr : 4'h0;
    assign dec_erise[i] = ec[PET_EVT_RISE_BIT-PET_EVT_CFG_LO];
    assign dec_efall[i] = ec[PET_EVT_FALL_BIT-PET_EVT_CFG_LO];
    assign dec_esingle[i] = ec[PET_EVT_SINGLE_BIT-PET_EVT_CFG_LO];
    assign dec_eroute[i*4 +: 4] = (er <= PET_PIN_MAX) ? er : 4'h0;
    assign ext_word[2*i] = q.cur.det[i];
    assign ext_word[2*i+1] = q.cur.rise[i];
  end

  always_comb begin
    logic [15:0] st;
    logic [2:0] num;
    logic found;
    logic mult;
    st = '0;
    num = '0;
    found = 1'b0;
    mult = 1'b0;
    next_q = q;
    q_pop = 1'b0;
    trig_bus.wr = 1'b0;
    trig_bus.wdata = i_hwdata[15:0];
    evt_bus.wr = 1'b0;
    evt_bus.wdata = i_hwdata[15:0];
    for (int u = 0; u < PET_UNITS; u++) begin
      if (q_head.det[u]) begin
        if (found) mult = 1'b1;
        else num = u[2:0];
        found = 1'b1;
      end
    end
    if (q.pend) begin
      next_q.pend = 1'b0;
      next_q.hready = 1'b1;
      next_q.hrdata = '0;
      if (q.pend_mapped) begin
        case (q.pend_idx)
          PET_IDX_PAGE_SELECT: begin
            if (q.pend_write) next_q.page = i_hwdata[2:0];
            else next_q.hrdata = {13'h0000, q.page};
          end
          PET_IDX_TRIGGER_CONFIGURATION: begin
            if (q.page == PET_PAGE_CONFIG) begin
              // strobe bit and bits 6:4 never reach the read path
              if (q.pend_write) trig_bus.wr = 1'b1;
              else next_q.hrdata = trig_bus.rdata;
            end
          end
          PET_IDX_EVENT_UNIT_CONFIGURATION: begin
            if (q.page == PET_PAGE_CONFIG) begin
              if (q.pend_write) evt_bus.wr = 1'b1;
              else next_q.hrdata = evt_bus.rdata;
            end
          end
          PET_IDX_EVENT_QUEUE_STATUS: begin
            if ((q.page == PET_PAGE_STATUS) && !q.pend_write) begin
              if (!q_empty) begin
                st[PET_ST_DET_BIT] = 1'b1;
                st[PET_ST_MULT_BIT] = mult;
                st[PET_ST_NUM_LO +: 3] = num;
                st[PET_ST_RF_BIT] = q_head.rise[num];
                st[PET_ST_LEN_LO +: 2] = q_head.len;
                st[PET_ST_MISSED_LO +: 3] = q_head.missed;
              end
              next_q.hrdata = st;
              q_pop = !q_empty;
              next_q.cur = q_head;
              next_q.cur_valid = !q_empty;
              // unread fields of the previous timestamp are dropped
              next_q.seq = mult ? PET_SEQ_EXT : PET_SEQ_NS_LO;
            end
          end
          PET_IDX_EVENT_TIMESTAMP_DATA: begin
            if ((q.page == PET_PAGE_STATUS) && !q.pend_write && q.cur_valid) begin
              case (q.seq)
                PET_SEQ_EXT: begin
                  next_q.hrdata = ext_word;
                  next_q.cur.det = '0;
                  next_q.cur.rise = '0;
                  next_q.seq = PET_SEQ_NS_LO;
                end
                PET_SEQ_NS_LO: begin
                  next_q.hrdata = q.cur.ns[15:0];
                  next_q.seq = PET_SEQ_NS_HI;
                end
                PET_SEQ_NS_HI: begin
                  next_q.hrdata = {2'b00, q.cur.ns[29:16]};
                  next_q.seq = PET_SEQ_SEC_LO;
                end
                PET_SEQ_SEC_LO: begin
                  next_q.hrdata = q.cur.sec[15:0];
                  next_q.seq = PET_SEQ_SEC_HI;
                end
                PET_SEQ_SEC_HI: begin
                  next_q.hrdata = q.cur.sec[31:16];
                  next_q.seq = PET_SEQ_DONE;
                end
                PET_SEQ_DONE: begin
                  next_q.hrdata = '0;
                end
                default: begin
                  next_q.seq = PET_SEQ_DONE;
                end
              endcase
            end
          end
          default: begin
            next_q.hrdata = '0;
          end
        endcase
      end
    end
    if (i_hsel && i_htrans[1] && i_hready) begin
      next_q.pend = 1'b1;
      next_q.hready = 1'b0;
      next_q.pend_write = i_hwrite;
      next_q.pend_idx = i_haddr[9:2];
      next_q.pend_mapped = (i_haddr[31:10] == 22'h0);
    end
    next_q.pulse_output_select = dec_pulse;
    next_q.trig_periodic = dec_periodic;
    next_q.trig_fire_late = dec_late;
    next_q.trig_report_done = dec_done;
    next_q.trig_report_late = dec_late_rpt;
    next_q.invert_output_mode = dec_toggle;
    next_q.trig_route = dec_troute;
    next_q.evt_rise = dec_erise;
    next_q.evt_fall = dec_efall;
    next_q.evt_single = dec_esingle;
    next_q.evt_route = dec_eroute;
  end

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.page <= PET_PAGE_RST;
      q.hready <= 1'b1;
      q.seq <= PET_SEQ_DONE;
    end else begin
      q <= next_q;
    end
  end

  assign o_hreadyout = q.hready;
  assign o_hresp = 1'b0;
  assign o_hrdata = {16'h0000, q.hrdata};
  assign o_pulse_output_select = q.pulse_output_select;
  assign o_trig_periodic = q.trig_periodic;
  assign o_trig_fire_late = q.trig_fire_late;
  assign o_trig_report_done = q.trig_report_done;
  assign o_trig_report_late = q.trig_report_late;
  assign o_invert_output_mode = q.invert_output_mode;
  assign o_trig_pin_route = q.trig_route;
  assign o_evt_rise_en = q.evt_rise;
  assign o_evt_fall_en = q.evt_fall;
  assign o_evt_single = q.evt_single;
  assign o_evt_pin_route = q.evt_route;
endmodule
`default_nettype wire

// >>> tb/pet_top_checker.sv
`timescale 1ns/1ps
`default_nettype none
module pet_top_checker import pet_pkg::*; (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_resetn,
  // bus
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic i_hready,
  input wire logic o_hreadyout,
  input wire logic [31:0] o_hrdata,
  // decoded controls
  input wire logic [PET_UNITS-1:0] o_pulse_output_select,
  input wire logic [PET_UNITS-1:0] o_trig_periodic,
  input wire logic [PET_UNITS-1:0] o_trig_fire_late,
  input wire logic [PET_UNITS-1:0] o_trig_report_done,
  input wire logic [PET_UNITS-1:0] o_trig_report_late,
  input wire logic [PET_UNITS-1:0] o_invert_output_mode,
  input wire logic [PET_UNITS*4-1:0] o_trig_pin_route,
  input wire logic [PET_UNITS-1:0] o_evt_rise_en,
  input wire logic [PET_UNITS-1:0] o_evt_fall_en,
  input wire logic [PET_UNITS-1:0] o_evt_single,
  input wire logic [PET_UNITS*4-1:0] o_evt_pin_route
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  logic take;
  logic wt;
  logic [79:0] tv;
  logic [55:0] ev;
  assign take = i_hsel & i_htrans[1] & i_hready;
  assign wt = take & i_hwrite;
  assign tv = {o_pulse_output_select, o_trig_periodic, o_trig_fire_late, o_trig_report_done, o_trig_report_late,
               o_invert_output_mode, o_trig_pin_route};
  assign ev = {o_evt_rise_en, o_evt_fall_en, o_evt_single, o_evt_pin_route};
  function automatic logic route_ok(input logic [31:0] rt);
    for (int j = 0; j < 8; j++) begin
      if (rt[j*4+:4] > PET_PIN_MAX) return 1'b0;
    end
    return 1'b1;
  endfunction
  wait_state_a: assert property (take |=> !o_hreadyout ##1 o_hreadyout)
    else $error("hreadyout not low for exactly one cycle");
  trig_rsvd_a: assert property (take && !i_hwrite && i_haddr == 32'h0000_0050 |-> ##2 (o_hrdata & 32'hffff_0071) == 32'h0)
    else $error("trigger readback has reserved or strobe bits set");
  evt_rsvd_a: assert property (take && !i_hwrite && i_haddr == 32'h0000_0054 |-> ##2 (o_hrdata & 32'hffff_80f1) == 32'h0)
    else $error("event unit readback has reserved or strobe bits set");
  upper_half_a: assert property (take && !i_hwrite |-> ##2 o_hrdata[31:16] == 16'h0000)
    else $error("read data wider than sixteen bits");
  late_notice_a: assert property (o_trig_report_late == (o_trig_report_done & ~(o_trig_periodic & o_trig_fire_late)))
    else $error("late report enable wrong");
  trig_route_a: assert property (route_ok(o_trig_pin_route))
    else $error("trigger pin route above twelve");
  evt_route_a: assert property (route_ok(o_evt_pin_route))
    else $error("event pin route above twelve");
  trig_hold_a: assert property (!$stable(tv) |-> $past(wt, 2) || $past(wt, 3))
    else $error("trigger controls changed without a write");
  evt_hold_a: assert property (!$stable(ev) |-> $past(wt, 2) || $past(wt, 3))
    else $error("event controls changed without a write");
  cover property (wt);
  cover property (take && !i_hwrite && i_haddr == 32'h0000_0078);
  cover property (|o_pulse_output_select);
  cover property (|o_evt_pin_route);
endmodule
bind pet_top pet_top_checker u_pet_top_checker (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_hsel(i_hsel),
  .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hready(i_hready), .o_hreadyout(o_hreadyout),
  .o_hrdata(o_hrdata), .o_pulse_output_select(o_pulse_output_select), .o_trig_periodic(o_trig_periodic),
  .o_trig_fire_late(o_trig_fire_late), .o_trig_report_done(o_trig_report_done),
  .o_trig_report_late(o_trig_report_late), .o_invert_output_mode(o_invert_output_mode), .o_trig_pin_route(o_trig_pin_route),
  .o_evt_rise_en(o_evt_rise_en), .o_evt_fall_en(o_evt_fall_en), .o_evt_single(o_evt_single),
  .o_evt_pin_route(o_evt_pin_route));
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel, hwrite, hresp, cap_valid;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, a, d, trt, ert;
  logic [29:0] cap_ns, pn;
  logic [31:0] cap_sec, ps;
  logic [7:0] cap_det, cap_rise, tpu, tpe, tfl, trd, trl, ttg, ere, efe, esg;
  wire hready;
  int err_total = 0;
  int n_tests = 0;
  int seed = 32'h0e8e;
  int n, r, i, k, lim;
  logic [15:0] v, m;
  logic [15:0] cfg [2][8];
  logic [7:0] dq [6], rq [6];
  logic [29:0] nq [6];
  logic [31:0] sq [6];
  logic [15:0] stq [6];
  logic [31:0] zq [4] = '{32'h0000_0050, 32'h0000_0054, 32'h0000_0060, 32'h0000_0400};
  logic [63:0] ts;
  logic [1:0] ln;

  always #4 clk = ~clk;

  pet_top u_pet_top (.i_core_clk(clk), .i_resetn(rst_n), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready), .o_hreadyout(hready),
    .o_hresp(hresp), .o_hrdata(hrdata), .i_cap_valid(cap_valid), .i_cap_det(cap_det), .i_cap_rise(cap_rise),
    .i_cap_ns(cap_ns), .i_cap_sec(cap_sec), .o_pulse_output_select(tpu), .o_trig_periodic(tpe), .o_trig_fire_late(tfl),
    .o_trig_report_done(trd), .o_trig_report_late(trl), .o_invert_output_mode(ttg), .o_trig_pin_route(trt),
    .o_evt_rise_en(ere), .o_evt_fall_en(efe), .o_evt_single(esg), .o_evt_pin_route(ert));

  task automatic give_verdict();
    $display("errors %0d in %0d checks", err_total, n_tests);
    if (err_total == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // entered just after a rising edge
  task automatic ahb(input logic w, input logic [31:0] ad, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= ad;
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask

  task automatic push(input logic [7:0] dt, input logic [7:0] rs, input logic [29:0] ns, input logic [31:0] sc);
    cap_valid <= 1'b1;
    cap_det <= dt;
    cap_rise <= rs;
    cap_ns <= ns;
    cap_sec <= sc;
    @(posedge clk);
    cap_valid <= 1'b0;
    @(posedge clk);
  endtask

  function automatic logic [15:0] stat_of(input logic [7:0] dt, input logic [7:0] rs, input logic [1:0] l);
    logic [2:0] num;
    num = 3'h0;
    for (int j = 7; j >= 0; j--) if (dt[j]) num = 3'(j);
    return {8'h00, l, rs[num], num, $countones(dt) > 1, 1'b1};
  endfunction

  function automatic logic [31:0] ext_of(input logic [7:0] dt, input logic [7:0] rs);
    ext_of = 32'h0;
    for (int j = 0; j < 8; j++) begin
      ext_of[2*j] = dt[j];
      ext_of[2*j+1] = rs[j];
    end
  endfunction

  function automatic logic [31:0] trig_exp(input logic [15:0] c);
    return {22'h0, c[15:12], c[12] & !(c[14] & c[13]), c[7], (c[11:8] > 4'hc) ? 4'h0 : c[11:8]};
  endfunction

  function automatic logic [31:0] evt_exp(input logic [15:0] c);
    return {25'h0, c[14:12], (c[11:8] > 4'hc) ? 4'h0 : c[11:8]};
  endfunction

  initial begin
    #160000;
    err_total++;
    give_verdict();
  end

  initial begin
    {hsel, hwrite, cap_valid, htrans, haddr, hwdata, cap_det, cap_rise, cap_ns, cap_sec} <= '0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    ahb(0, 32'h0000_004c, 0, d);
    chk(d, 32'h0);
    ahb(1, 32'h0000_004c, 32'h0000_fffd, d);
    ahb(0, 32'h0000_004c, 0, d);
    chk(d, 32'h5);
    foreach (zq[j]) begin
      ahb(0, zq[j], 0, d);
      chk(d, 32'h0);
    end
    for (r = 0; r < 2; r++) begin
      a = r ? 32'h0000_0054 : 32'h0000_0050;
      m = r ? 16'h7f00 : 16'hff80;
      for (n = 0; n < 8; n++) begin
        v = 16'($random(seed));
        if (n < 2) v[11:8] = 4'hc + 4'(n);
        cfg[r][n] = v & m;
        ahb(1, a, {16'h0, v[15:4], 3'(n), 1'b1}, d);
      end
      for (n = 7; n >= 0; n--) begin
        v = 16'($random(seed));
        ahb(1, a, {16'h0, v[15:4], 3'(n), 1'b0}, d);
        ahb(0, a, 0, d);
        chk(d, {16'h0, cfg[r][n] | {12'h0, 3'(n), 1'b0}});
      end
    end
    repeat (3) @(posedge clk);
    for (n = 0; n < 8; n++) begin
      chk({tpu[n], tpe[n], tfl[n], trd[n], trl[n], ttg[n], trt[n*4+:4]}, trig_exp(cfg[0][n]));
      chk({ere[n], efe[n], esg[n], ert[n*4+:4]}, evt_exp(cfg[1][n]));
    end
    ahb(1, 32'h0000_004c, 32'h4, d);
    ahb(0, 32'h0000_0050, 0, d);
    chk(d, 32'h0);
    ahb(0, 32'h0000_0078, 0, d);
    chk(d, 32'h0);
    ahb(0, 32'h0000_007c, 0, d);
    chk(d, 32'h0);
    pn = '0;
    ps = '0;
    for (i = 0; i < 6; i++) begin
      dq[i] = (i == 0) ? 8'h01 : (i == 1) ? 8'h81 : (i == 2) ? 8'h80 : 8'($random(seed));
      if (dq[i] == 8'h00) dq[i] = 8'h24;
      rq[i] = 8'($random(seed)) & dq[i];
      nq[i] = pn;
      sq[i] = ps;
      v = 16'($random(seed));
      case (i % 4)
        0: nq[i][15:0] = v;
        1: nq[i][29:16] = v[13:0];
        2: sq[i][15:0] = v;
        default: sq[i][31:16] = v;
      endcase
      ln = (sq[i][31:16] != ps[31:16]) ? 2'd3 : (sq[i][15:0] != ps[15:0]) ? 2'd2 :
           (nq[i][29:16] != pn[29:16]) ? 2'd1 : 2'd0;
      stq[i] = stat_of(dq[i], rq[i], ln);
      pn = nq[i];
      ps = sq[i];
      push(dq[i], rq[i], nq[i], sq[i]);
    end
    ahb(1, 32'h0000_004c, 32'h5, d);
    ahb(0, 32'h0000_0078, 0, d);
    chk(d, 32'h0);
    ahb(1, 32'h0000_004c, 32'h4, d);
    for (i = 0; i < 6; i++) begin
      ahb(0, 32'h0000_0078, 0, d);
      chk(d, {16'h0, stq[i]});
      if (stq[i][1]) begin
        ahb(0, 32'h0000_007c, 0, d);
        chk(d, ext_of(dq[i], rq[i]));
      end
      ts = {sq[i], 2'b00, nq[i]};
      lim = (i == 1) ? 1 : 5;
      for (k = 0; k < lim; k++) begin
        ahb(0, 32'h0000_007c, 0, d);
        chk(d, (k < 4) ? {16'h0, ts[k*16+:16]} : 32'h0);
      end
    end
    // fill the queue, drop one, then store one carrying the missed count
    for (i = 0; i < 10; i++) begin
      if (i == 9) ahb(0, 32'h0000_0078, 0, d);
      push(8'h01, 8'h00, pn, ps);
    end
    chk(d, 32'h1);
    for (i = 0; i < 8; i++) begin
      ahb(0, 32'h0000_0078, 0, d);
      chk(d, (i == 7) ? 32'h0000_0101 : 32'h0000_0001);
    end
    ahb(0, 32'h0000_0078, 0, d);
    chk(d, 32'h0);
    ahb(0, 32'h0000_007c, 0, d);
    chk(d, 32'h0);
    give_verdict();
  end
endmodule
`default_nettype wire
